// *** design/ats_trip_supervisor.sv ***
// Arc trip supervision and output logic
`include "ats_map.svh"
// Notes on behaviour
// - Healthy: power LED on and system-failure relay energized.
// - Internal or supply fault drops the relay and lights the error LED.
// - Failed sensor channel blinks, is blocked; other channels still protect.
// - Failure status clears itself once the error disappears.
// - Stays in error until every disconnected sensor is restored.
// - Live switches are compared with stored settings all the time.
// - Switch mismatch raises alarm; stored settings stay in force.
// - Two normally-open trip outputs close on a trip condition.
// - Lock-out output latches until reset press; survives power loss.
// - Lock-out state restored after power return from non-volatile copy.
// - Common trip output is OR of the two primary trip outputs.
// - Four point channels, up to three series sensors each.
// - Fiber loop tested by 60 us pulse; no return sets error.
// - First binary input is always the secondary trip criterion.
// - Second binary input selectable as direct trip or light.
// - Binary output source selected by switches, never latched.
// - Push button clears all latched indications and outputs.
// - Light-only mode: light trips and lights channel, output LEDs.
// - Second input as master trip operates trips without light.
// - Binary output LED follows binary output.
// - Light-and-current mode: light alone does not trip; lights channel LED, binary output if set to light.
// - Light plus criterion beyond breaker-failure delay drives trip b, output.
module ats_trip_supervisor #(
	parameter int NCH = `ATS_NCH,
	parameter int CFG_W = `ATS_CFG_W,
	parameter int BLINK_CYC = `ATS_BLINK_CYC,
	parameter int PULSE_CYC = `ATS_PULSE_CYC,
	parameter int LOOP_PERIOD_CYC = `ATS_LOOP_PERIOD_CYC,
	parameter int CBF_SHORT_CYC = `ATS_CBF_SHORT_CYC,
	parameter int CBF_LONG_CYC = `ATS_CBF_LONG_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [NCH-1:0] point_light_i,
	input wire logic [NCH-1:0] point_fault_i,
	input wire logic fiber_present_i,
	input wire logic fiber_light_i,
	input wire logic fiber_return_i,
	input wire logic secondary_criterion_input_i,
	input wire logic aux_trip_light_input_i,
	input wire logic reset_button_i,
	input wire logic [CFG_W-1:0] config_switch_i,
	input wire logic [CFG_W-1:0] stored_config_i,
	input wire logic internal_fault_i,
	input wire logic supply_fail_i,
	input wire logic nv_lockout_i,
	output logic trip_out_a_o,
	output logic trip_out_b_o,
	output logic lockout_trip_out_o,
	output logic common_trip_out_o,
	output logic config_binary_output_o,
	output logic system_failure_relay_o,
	output logic fiber_tx_o,
	output logic nv_lockout_o,
	output logic power_led_o,
	output logic error_led_o,
	output logic [NCH:0] channel_led_o,
	output logic trip_a_led_o,
	output logic trip_b_led_o,
	output logic lockout_led_o,
	output logic binary_out_led_o,
	output logic criterion_led_o,
	output logic config_mismatch_o
);
	import ats_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int SW = 2 * NCH + CFG_W + 8;
	logic [SW-1:0] raw_w;
	logic [SW-1:0] syn_w;
	assign raw_w = {point_light_i, point_fault_i, config_switch_i,
		fiber_present_i, fiber_light_i, fiber_return_i,
		secondary_criterion_input_i, aux_trip_light_input_i,
		reset_button_i, internal_fault_i, supply_fail_i};
	ats_sync #(.W(SW)) u_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.d_i(raw_w),
		.q_o(syn_w)
	);
	logic [NCH-1:0] light_w;
	logic [NCH-1:0] pfault_w;
	logic [CFG_W-1:0] sw_w;
	logic fib_pres_w, fib_light_w, fib_ret_w, crit_w, aux_w, btn_w;
	logic int_flt_w, sup_flt_w;
	assign {light_w, pfault_w, sw_w, fib_pres_w, fib_light_w, fib_ret_w,
		crit_w, aux_w, btn_w, int_flt_w, sup_flt_w} = syn_w;

	// ------------------------------------------------------------
	// Stored settings and mismatch
	// ------------------------------------------------------------
	// Stored image is a level from same-domain NV logic, taken as is
	logic [CFG_W-1:0] cfg_w;
	logic mismatch_w;
	assign cfg_w = stored_config_i;
	assign mismatch_w = (sw_w != cfg_w);
	logic mode_lc_w, aux_trip_w, lock_en_w, cbf_en_w, cbf_long_w;
	logic trip_b_en_w;
	ats_bo_sel_e bo_sel_w;
	assign mode_lc_w = cfg_w[`ATS_CFG_MODE_BIT];
	assign aux_trip_w = cfg_w[`ATS_CFG_AUX_TRIP_BIT];
	assign lock_en_w = cfg_w[`ATS_CFG_LOCKOUT_BIT];
	assign cbf_en_w = cfg_w[`ATS_CFG_CBF_EN_BIT];
	assign cbf_long_w = cfg_w[`ATS_CFG_CBF_LONG_BIT];
	assign trip_b_en_w = cfg_w[`ATS_CFG_TRIP_B_BIT];
	assign bo_sel_w = ats_bo_sel_e'(
		cfg_w[`ATS_CFG_BO_SEL_MSB:`ATS_CFG_BO_SEL_LSB]);

	// ------------------------------------------------------------
	// Fiber loop test pulse
	// ------------------------------------------------------------
	ats_loop_st_e lp_r, lp_nxt;
	logic [31:0] lp_cnt_r, lp_cnt_nxt;
	logic seen_r, seen_nxt;
	logic fib_fail_r, fib_fail_nxt;
	always_comb
	begin
		lp_nxt = lp_r;
		lp_cnt_nxt = lp_cnt_r + 32'h0000_0001;
		seen_nxt = seen_r | fib_ret_w;
		fib_fail_nxt = fib_fail_r;
		case (lp_r)
			ATS_LP_IDLE:
			begin
				seen_nxt = 1'b0;
				if (lp_cnt_r >= 32'(LOOP_PERIOD_CYC))
				begin
					lp_nxt = ATS_LP_PULSE;
					lp_cnt_nxt = '0;
				end
			end
			ATS_LP_PULSE:
				if (lp_cnt_r >= 32'(PULSE_CYC - 1))
				begin
					lp_nxt = ATS_LP_WAIT;
					lp_cnt_nxt = '0;
				end
			ATS_LP_WAIT:
			begin
				// Returned pulse may lag through the synchroniser
				if (lp_cnt_r >= 32'(`ATS_RET_SLACK_CYC))
				begin
					fib_fail_nxt = fib_pres_w & ~seen_r;
					lp_nxt = ATS_LP_IDLE;
					lp_cnt_nxt = '0;
				end
			end
			default:
			begin
				lp_nxt = ATS_LP_IDLE;
				lp_cnt_nxt = '0;
			end
		endcase
		if (!fib_pres_w)
			fib_fail_nxt = 1'b0;
	end

	// ------------------------------------------------------------
	// Trip decision
	// ------------------------------------------------------------
	logic [NCH:0] ch_light_w;
	logic [NCH:0] ch_bad_w;
	logic any_light_w, light_trip_w, master_w, trip_w, cbf_hit_w;
	logic [31:0] cbf_cnt_r, cbf_cnt_nxt;
	logic [31:0] cbf_lim_w;
	assign ch_bad_w = {fib_fail_r, pfault_w};
	// Blocked channels never count as light
	assign ch_light_w = {fib_light_w, light_w} & ~ch_bad_w;
	assign any_light_w = (|ch_light_w) | (aux_w & ~aux_trip_w);
	assign master_w = aux_w & aux_trip_w;
	assign light_trip_w = any_light_w & (~mode_lc_w | crit_w);
	assign trip_w = light_trip_w | master_w;
	assign cbf_lim_w = cbf_long_w ? 32'(CBF_LONG_CYC) : 32'(CBF_SHORT_CYC);
	assign cbf_hit_w = cbf_en_w & (cbf_cnt_r >= cbf_lim_w);
	always_comb
	begin
		cbf_cnt_nxt = '0;
		if (any_light_w && crit_w)
			cbf_cnt_nxt = cbf_hit_w ? cbf_cnt_r : cbf_cnt_r + 32'h0000_0001;
	end

	// ------------------------------------------------------------
	// Latches, cleared only by the button
	// ------------------------------------------------------------
	logic ta_r, ta_nxt, tb_r, tb_nxt, lo_r, lo_nxt;
	logic [NCH:0] led_r, led_nxt;
	logic crit_led_r, crit_led_nxt;
	logic lo_init_r;
	// Trip input held during the press re-latches: set wins
	assign ta_nxt = trip_w | (ta_r & ~btn_w);
	assign tb_nxt = ((trip_w & trip_b_en_w) | cbf_hit_w)
		| (tb_r & ~btn_w);
	assign lo_nxt = (lock_en_w & trip_w) | (lo_r & ~btn_w);
	assign led_nxt = ch_light_w | (led_r & ~{(NCH+1){btn_w}});
	assign crit_led_nxt = crit_w | (crit_led_r & ~btn_w);

	// ------------------------------------------------------------
	// Supervision, blink, binary output
	// ------------------------------------------------------------
	logic fail_w, bo_w;
	logic [31:0] blink_cnt_r, blink_cnt_nxt;
	logic blink_r, blink_nxt;
	// Failure clears once every cause has cleared, no latch
	assign fail_w = int_flt_w | sup_flt_w | (|ch_bad_w)
		| mismatch_w;
	assign blink_nxt = (blink_cnt_r >= 32'(BLINK_CYC - 1)) ? ~blink_r
		: blink_r;
	assign blink_cnt_nxt = (blink_cnt_r >= 32'(BLINK_CYC - 1)) ? '0
		: blink_cnt_r + 32'h0000_0001;
	always_comb
	begin
		case (bo_sel_w)
			ATS_BO_LIGHT: bo_w = any_light_w;
			ATS_BO_TRIP: bo_w = trip_w;
			ATS_BO_CBF: bo_w = cbf_hit_w;
			default: bo_w = 1'b0;
		endcase
		// Breaker-failure always reaches the binary output
		bo_w = bo_w | cbf_hit_w;
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lp_r <= ATS_LP_IDLE;
			lp_cnt_r <= '0;
			seen_r <= 1'b0;
			fib_fail_r <= 1'b0;
			cbf_cnt_r <= '0;
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
		end
		else
		begin
			lp_r <= lp_nxt;
			lp_cnt_r <= lp_cnt_nxt;
			seen_r <= seen_nxt;
			fib_fail_r <= fib_fail_nxt;
			cbf_cnt_r <= cbf_cnt_nxt;
			blink_cnt_r <= blink_cnt_nxt;
			blink_r <= blink_nxt;
		end
	end

	// Lock-out reload from NV copy one cycle after reset release
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ta_r <= 1'b0;
			tb_r <= 1'b0;
			lo_r <= 1'b0;
			lo_init_r <= 1'b1;
			led_r <= '0;
			crit_led_r <= 1'b0;
		end
		else
		begin
			ta_r <= ta_nxt;
			tb_r <= tb_nxt;
			lo_init_r <= 1'b0;
			lo_r <= lo_init_r ? nv_lockout_i : lo_nxt;
			led_r <= led_nxt;
			crit_led_r <= crit_led_nxt;
		end
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trip_out_a_o <= 1'b0;
			trip_out_b_o <= 1'b0;
			lockout_trip_out_o <= 1'b0;
			common_trip_out_o <= 1'b0;
			config_binary_output_o <= 1'b0;
			system_failure_relay_o <= 1'b0;
			fiber_tx_o <= 1'b0;
			nv_lockout_o <= 1'b0;
			power_led_o <= 1'b0;
			error_led_o <= 1'b0;
			channel_led_o <= '0;
			trip_a_led_o <= 1'b0;
			trip_b_led_o <= 1'b0;
			lockout_led_o <= 1'b0;
			binary_out_led_o <= 1'b0;
			criterion_led_o <= 1'b0;
			config_mismatch_o <= 1'b0;
		end
		else
		begin
			trip_out_a_o <= ta_r;
			trip_out_b_o <= tb_r;
			lockout_trip_out_o <= lo_r;
			common_trip_out_o <= ta_r | tb_r;
			config_binary_output_o <= bo_w;
			system_failure_relay_o <= ~fail_w;
			fiber_tx_o <= (lp_r == ATS_LP_PULSE);
			nv_lockout_o <= lo_r;
			power_led_o <= ~fail_w;
			error_led_o <= fail_w;
			channel_led_o <= (led_r & ~ch_bad_w)
				| (ch_bad_w & {(NCH+1){blink_r}});
			trip_a_led_o <= ta_r;
			trip_b_led_o <= tb_r;
			lockout_led_o <= lo_r;
			binary_out_led_o <= bo_w;
			criterion_led_o <= crit_led_r;
			config_mismatch_o <= mismatch_w;
		end
	end
endmodule : ats_trip_supervisor

// *** include/ats_map.svh ***
// Constant map for the arc trip supervision block
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH
`define ATS_CLK_MHZ 100
`define ATS_BLINK_MS 500
`define ATS_BLINK_CYC (`ATS_BLINK_MS * 1000 * `ATS_CLK_MHZ / 2)
`define ATS_PULSE_US 60
`define ATS_PULSE_CYC (`ATS_PULSE_US * `ATS_CLK_MHZ)
`define ATS_LOOP_PERIOD_CYC 100000
`define ATS_RET_SLACK_CYC 3
`define ATS_CBF_SHORT_MS 100
`define ATS_CBF_LONG_MS 150
`define ATS_CBF_SHORT_CYC (`ATS_CBF_SHORT_MS * 1000 * `ATS_CLK_MHZ)
`define ATS_CBF_LONG_CYC (`ATS_CBF_LONG_MS * 1000 * `ATS_CLK_MHZ)
`define ATS_NCH 4
`define ATS_CFG_W 8
`define ATS_CFG_MODE_BIT 0
`define ATS_CFG_AUX_TRIP_BIT 1
`define ATS_CFG_LOCKOUT_BIT 2
`define ATS_CFG_CBF_EN_BIT 3
`define ATS_CFG_CBF_LONG_BIT 4
`define ATS_CFG_BO_SEL_LSB 5
`define ATS_CFG_BO_SEL_MSB 6
`define ATS_CFG_TRIP_B_BIT 7
`endif

// *** include/ats_pkg.sv ***
// Types shared by the arc trip supervision block
package ats_pkg;
	typedef enum logic [1:0]
	{
		ATS_BO_LIGHT = 2'b00,
		ATS_BO_TRIP = 2'b01,
		ATS_BO_CBF = 2'b10,
		ATS_BO_OFF = 2'b11
	} ats_bo_sel_e;
	typedef enum logic [1:0]
	{
		ATS_LP_IDLE = 2'b00,
		ATS_LP_PULSE = 2'b01,
		ATS_LP_WAIT = 2'b10
	} ats_loop_st_e;
endpackage : ats_pkg

// *** design/ats_sync.sv ***
// Two-flop synchroniser bank for pin inputs
module ats_sync #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_r <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : ats_sync

// *** sim/ats_checker.sv ***
// Port assertions for the arc trip supervision block
module ats_checker #(
	parameter int CFG_W = 8,
	parameter int PULSE_CYC = 6000
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic internal_fault_i,
	input wire logic supply_fail_i,
	input wire logic reset_button_i,
	input wire logic [CFG_W-1:0] config_switch_i,
	input wire logic [CFG_W-1:0] stored_config_i,
	input wire logic trip_out_a_o,
	input wire logic trip_out_b_o,
	input wire logic lockout_trip_out_o,
	input wire logic common_trip_out_o,
	input wire logic config_binary_output_o,
	input wire logic binary_out_led_o,
	input wire logic system_failure_relay_o,
	input wire logic error_led_o,
	input wire logic fiber_tx_o,
	input wire logic config_mismatch_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int tx_cnt_r;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Pulse width is a parameter, so it is counted, not unrolled
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
			tx_cnt_r <= 0;
		else
			tx_cnt_r <= fiber_tx_o ? tx_cnt_r + 1 : 0;
	common_or_a: assert property (
		common_trip_out_o == (trip_out_a_o | trip_out_b_o))
		else $error("common trip not a or b");
	bo_led_a: assert property (
		config_binary_output_o |-> ##[0:1] binary_out_led_o)
		else $error("binary output led missing");
	fault_relay_a: assert property (
		$rose(internal_fault_i) |-> ##[2:4] !system_failure_relay_o)
		else $error("relay held on internal fault");
	supply_err_a: assert property (
		$rose(supply_fail_i) |-> ##[2:4] error_led_o)
		else $error("error led off on supply fail");
	healthy_led_a: assert property (
		system_failure_relay_o |-> !error_led_o)
		else $error("error led on while relay energized");
	cfg_alarm_a: assert property (
		(config_switch_i != stored_config_i) [*4]
		|-> config_mismatch_o && !system_failure_relay_o)
		else $error("switch mismatch not alarmed");
	pulse_len_a: assert property (
		$fell(fiber_tx_o) |-> tx_cnt_r == PULSE_CYC)
		else $error("fiber test pulse width wrong");
	trip_hold_a: assert property (
		(trip_out_a_o && !reset_button_i) [*4] |=> trip_out_a_o)
		else $error("trip a released without button");
	lock_hold_a: assert property (
		(lockout_trip_out_o && !reset_button_i) [*4]
		|=> lockout_trip_out_o)
		else $error("lock-out released without button");
	cover property ($rose(trip_out_a_o));
	cover property ($rose(trip_out_b_o));
	cover property ($rose(lockout_trip_out_o));
	cover property ($fell(system_failure_relay_o));
endmodule : ats_checker

bind ats_trip_supervisor ats_checker #(
	.CFG_W(CFG_W),
	.PULSE_CYC(PULSE_CYC)
) i_ats_checker (.clock_i, .rst_i, .internal_fault_i, .supply_fail_i,
	.reset_button_i, .config_switch_i, .stored_config_i, .trip_out_a_o,
	.trip_out_b_o, .lockout_trip_out_o, .common_trip_out_o,
	.config_binary_output_o, .binary_out_led_o, .system_failure_relay_o,
	.error_led_o, .fiber_tx_o, .config_mismatch_o);

// *** sim/ats_loop_model.sv ***
// Fiber loop model: echoes the test pulse unless the loop is cut
module ats_loop_model (
	input wire logic clock_i,
	input wire logic loop_ok_i,
	input wire logic tx_i,
	output logic rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] dly_r;
	// Two cycles of flight time; a cut loop returns no light
	always_ff @(posedge clock_i)
		dly_r <= {dly_r[0], tx_i & loop_ok_i};
	assign rx_o = dly_r[1];
endmodule : ats_loop_model

// *** sim/tb.sv ***
// Self-checking testbench for the arc trip supervision block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ats_pkg::*;
	logic clock_i = 0, rst_i = 1, crit = 0, aux = 0, btn = 0, ifl = 0;
	logic sfl = 0, nvl = 0, ok = 1, rx, ta, tbo, lo, ct, bo, sf, tx, nvo;
	logic pw, el, tal, bol, crl, mm, tbl, lol, fp = 1, fl = 0;
	logic [3:0] pl = 0, pf = 0;
	logic [7:0] sw = 0, st = 0;
	logic [4:0] cl;
	int err_total = 0, compares = 0, h;
	always #5 clock_i = ~clock_i;
	ats_trip_supervisor #(.BLINK_CYC(8), .PULSE_CYC(10),
		.LOOP_PERIOD_CYC(50), .CBF_SHORT_CYC(20), .CBF_LONG_CYC(30))
	i_ats_trip_supervisor (.clock_i, .rst_i, .point_light_i(pl),
		.point_fault_i(pf), .fiber_present_i(fp), .fiber_light_i(fl),
		.fiber_return_i(rx), .secondary_criterion_input_i(crit),
		.aux_trip_light_input_i(aux), .reset_button_i(btn),
		.config_switch_i(sw), .stored_config_i(st), .internal_fault_i(ifl),
		.supply_fail_i(sfl), .nv_lockout_i(nvl), .trip_out_a_o(ta),
		.trip_out_b_o(tbo), .lockout_trip_out_o(lo), .common_trip_out_o(ct),
		.config_binary_output_o(bo), .system_failure_relay_o(sf),
		.fiber_tx_o(tx), .nv_lockout_o(nvo), .power_led_o(pw),
		.error_led_o(el), .channel_led_o(cl), .trip_a_led_o(tal),
		.trip_b_led_o(tbl), .lockout_led_o(lol), .binary_out_led_o(bol),
		.criterion_led_o(crl), .config_mismatch_o(mm));
	ats_loop_model i_ats_loop_model (.clock_i, .loop_ok_i(ok), .tx_i(tx),
		.rx_o(rx));
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cyc
	task chk(input string n, input logic e, input logic s);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %b got %b", n, e, s);
		end
	endtask : chk
	task close_out;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task wrel(input logic e);
		h = 0;
		while (sf !== e && h < 300)
		begin
			cyc(1);
			h++;
		end
		chk("relay", e, sf);
		if (sf !== e)
			close_out;
	endtask : wrel
	task cfg(input logic [7:0] v);
		@(posedge clock_i);
		sw <= v;
		st <= v;
		cyc(5);
	endtask : cfg
	task setl(input logic [3:0] v);
		@(posedge clock_i);
		pl <= v;
		cyc(5);
	endtask : setl
	task press;
		@(posedge clock_i);
		btn <= 1;
		@(posedge clock_i);
		btn <= 0;
		cyc(5);
	endtask : press
	task t_light;
		setl(1);
		chk("trip_a", 1, ta);
		chk("common", 1, ct);
		chk("trip_a_led", 1, tal);
		chk("ch0_led", 1, cl[0]);
		setl(0);
		chk("trip_a held", 1, ta);
		press;
		chk("trip_a clr", 0, ta);
		chk("ch0_led clr", 0, cl[0]);
		$display("test light done");
	endtask : t_light
	task t_modes;
		cfg(8'h01);
		setl(1);
		chk("lc trip", 0, ta);
		chk("lc led", 1, cl[0]);
		@(posedge clock_i);
		crit <= 1;
		cyc(5);
		chk("lc trip", 1, ta);
		chk("crit led", 1, crl);
		@(posedge clock_i);
		crit <= 0;
		pl <= 0;
		press;
		cfg(8'h02);
		@(posedge clock_i);
		aux <= 1;
		cyc(5);
		chk("master trip", 1, ta);
		@(posedge clock_i);
		aux <= 0;
		press;
		chk("master clr", 0, ta);
		$display("test modes done");
	endtask : t_modes
	task t_cbf;
		for (int k = 0; k < 2; k++)
		begin
			cfg({1'b0, ATS_BO_CBF, k[0], 4'h9});
			@(posedge clock_i);
			pl <= 1;
			crit <= 1;
			cyc(12 + 10 * k);
			chk("cbf early", 0, tbo);
			cyc(23);
			chk("cbf trip_b", 1, tbo);
			chk("trip_b led", 1, tbl);
			chk("cbf bo", 1, bo);
			chk("bo led", 1, bol);
			@(posedge clock_i);
			pl <= 0;
			crit <= 0;
			cyc(5);
			chk("bo follows", 0, bo);
			chk("trip_b held", 1, tbo);
			press;
		end
		cfg(8'h00);
		$display("test cbf done");
	endtask : t_cbf
	task t_sensor;
		@(posedge clock_i);
		pf <= 4'h2;
		cyc(5);
		chk("sensor relay", 0, sf);
		chk("sensor err", 1, el);
		h = 0;
		repeat (32)
		begin
			cyc(1);
			h += int'(cl[1] === 1'b1);
		end
		chk("blink", 1, h > 4 && h < 28);
		setl(2);
		chk("blocked", 0, ta);
		setl(6);
		chk("healthy trips", 1, ta);
		@(posedge clock_i);
		pl <= 0;
		pf <= 0;
		wrel(1);
		chk("err off", 0, el);
		press;
		$display("test sensor done");
	endtask : t_sensor
	task t_faults;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock_i);
			{ifl, sfl} <= k ? 2'b01 : 2'b10;
			cyc(5);
			chk("fault relay", 0, sf);
			chk("fault err", 1, el);
			@(posedge clock_i);
			{ifl, sfl} <= 2'b00;
			wrel(1);
		end
		@(posedge clock_i);
		ok <= 0;
		wrel(0);
		chk("loop err", 1, el);
		@(posedge clock_i);
		ok <= 1;
		wrel(1);
		@(posedge clock_i);
		sw <= 8'h01;
		cyc(5);
		chk("mismatch", 1, mm);
		setl(1);
		chk("stored used", 1, ta);
		@(posedge clock_i);
		pl <= 0;
		sw <= 0;
		press;
		wrel(1);
		$display("test faults done");
	endtask : t_faults
	task t_aux;
		cfg(8'h80);
		@(posedge clock_i);
		aux <= 1;
		cyc(5);
		chk("aux light trip", 1, ta);
		chk("trip_b enabled", 1, tbo);
		chk("trip_b led", 1, tbl);
		chk("bo light", 1, bo);
		chk("bo led", 1, bol);
		@(posedge clock_i);
		aux <= 0;
		cyc(5);
		chk("bo light off", 0, bo);
		press;
		cfg(8'h20);
		@(posedge clock_i);
		fl <= 1;
		cyc(5);
		chk("fiber led", 1, cl[4]);
		chk("fiber trip", 1, ta);
		chk("bo trip", 1, bo);
		@(posedge clock_i);
		fl <= 0;
		cyc(5);
		chk("bo trip off", 0, bo);
		press;
		chk("fiber led clr", 0, cl[4]);
		cfg(8'h60);
		setl(1);
		chk("bo off", 0, bo);
		@(posedge clock_i);
		pl <= 0;
		press;
		@(posedge clock_i);
		fp <= 0;
		ok <= 0;
		cyc(80);
		chk("no loop fitted", 1, sf);
		@(posedge clock_i);
		ok <= 1;
		cyc(80);
		@(posedge clock_i);
		fp <= 1;
		cfg(8'h00);
		$display("test aux done");
	endtask : t_aux
	task t_lock;
		cfg(8'h04);
		setl(1);
		setl(0);
		chk("lockout", 1, lo);
		chk("lockout led", 1, lol);
		chk("nv mirror", 1, nvo);
		@(posedge clock_i);
		rst_i <= 1;
		nvl <= 1;
		cyc(3);
		@(posedge clock_i);
		rst_i <= 0;
		cyc(4);
		chk("lock restore", 1, lo);
		@(posedge clock_i);
		nvl <= 0;
		press;
		chk("lock clr", 0, lo);
		$display("test lock done");
	endtask : t_lock
	initial
	begin
		cyc(20);
		@(posedge clock_i);
		rst_i <= 0;
		wrel(1);
		chk("power led", 1, pw);
		t_light;
		t_modes;
		t_cbf;
		t_sensor;
		t_faults;
		t_aux;
		t_lock;
		close_out;
	end
endmodule : tb
